// file: hdl/prodinfo_pkg.sv
/*
 package for the product information register window: register numbers,
 field positions, reset values and the request and answer carriers.
 assumes register numbers are the raw address field of each request.
*/
package prodinfo_pkg;

   // ==========================================================
   // register numbers
   localparam logic [15:0] ADDR_LANGUAGE = 16'h400c;
   localparam logic [15:0] ADDR_FW_BUILD = 16'h400d;
   localparam logic [15:0] ADDR_SUPPORT = 16'h400f;
   localparam logic [15:0] ADDR_TIMEOUT = 16'h4010;
   localparam logic [15:0] ADDR_RSVD_A_LO = 16'h4011;
   localparam logic [15:0] ADDR_RSVD_A_HI = 16'h4013;
   localparam logic [15:0] ADDR_CONFIGURED = 16'h4014;
   localparam logic [15:0] ADDR_RSVD_B = 16'h4015;
   localparam logic [15:0] ADDR_ERR_FLAGS = 16'h4016;
   localparam logic [15:0] ADDR_ERR_LOC = 16'h4017;
   localparam logic [15:0] ADDR_RSVD_C_LO = 16'h4018;
   localparam logic [15:0] ADDR_RSVD_C_HI = 16'h401f;

   // ==========================================================
   // fields and values
   localparam logic [3:0] LANG_ENGLISH = 4'h0;
   localparam logic [3:0] LANG_MAX = 4'h9;
   localparam int SUPPORT_IO2_BIT = 0;
   localparam int CONFIGURED_BIT = 0;
   // bits 9, 14 and 15 of the error word never set
   localparam logic [15:0] ERR_VALID_MASK = 16'h3dff;
   localparam logic [15:0] TIMEOUT_MIN = 16'h01f4;
   localparam logic [15:0] TIMEOUT_RESET = 16'h02ee;
   localparam logic [15:0] ERR_FLAGS_RESET = 16'h0000;
   localparam logic [15:0] ERR_LOC_RESET = 16'h0000;
   localparam logic [15:0] RSVD_VALUE = 16'h0000;

   // ==========================================================
   // exception answers
   localparam logic [7:0] EXC_NONE = 8'h00;
   localparam logic [7:0] EXC_BAD_ADDR = 8'h02;
   localparam logic [7:0] EXC_BAD_VALUE = 8'h03;

   typedef struct packed {
      logic valid;
      logic write;
      logic [15:0] addr;
      logic [15:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic ack;
      logic [7:0] exc;
      logic [15:0] rdata;
   } reg_rsp_t;

   typedef struct packed {
      logic [15:0] set;
      logic [15:0] clr;
      logic [15:0] addr;
   } err_evt_t;

endpackage

// file: hdl/product_info_status_registers.sv
/*
 product information and status register window behind the request port.
 assumes the protocol engine hands one decoded register request at a time,
 and that status inputs come from logic on the same clock.
*/
// Functional notes
// R1 - language code also reports 7 Mandarin Chinese, 8 Russian, 9 Dutch
// R2 - language codes 0 through 6 as listed, default English zero
// R3 - product support word read-only, bit 0 second io card, rest reserved
// R4 - settings timeout read/write milliseconds, 500 to 65535, resets to 750
// R5 - configuration word read-only, bit 0 unit configured, default zero
// R6 - error word read-only, default zero, bits 0 to 7 settings errors
// R7 - error bits 8, 10 to 13 as listed, bit 14 reserved
// R8 - every reserved location reads back as zero
// R9 - access follows tags; writes to read-only locations are refused
// R10 - master uses listed register numbers as the request address field
// R11 - error address word captures the address of the latest flagged error
`timescale 1ns/1ps

module product_info_status_registers #(
   // arbitrary neutral build value
   parameter logic [15:0] FW_BUILD = 16'h0001
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire prodinfo_pkg::reg_req_t req_i,
   input wire logic [3:0] language_i,
   input wire logic io2_installed_i,
   input wire logic unit_configured_i,
   input wire prodinfo_pkg::err_evt_t err_evt_i,
   output prodinfo_pkg::reg_rsp_t rsp_o,
   output logic [15:0] timeout_ms_o,
   output logic [15:0] error_flags_o
);

   // ==========================================================
   // state
   typedef struct packed {
      prodinfo_pkg::reg_rsp_t rsp;
      logic [15:0] timeout;
      logic [15:0] err_flags;
      logic [15:0] err_loc;
      logic [3:0] lang;
      logic io2;
      logic configured;
   } state_t;

   state_t state;
   state_t next_state;

   // ==========================================================
   // register classes
   typedef enum logic [3:0] {
      REG_LANGUAGE,
      REG_FW_BUILD,
      REG_SUPPORT,
      REG_TIMEOUT,
      REG_CONFIGURED,
      REG_ERR_FLAGS,
      REG_ERR_LOC,
      REG_RESERVED,
      REG_NONE
   } reg_sel_t;

   // ==========================================================
   // helpers
   function automatic logic in_range(input logic [15:0] a,
                                     input logic [15:0] lo,
                                     input logic [15:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction

   function automatic logic is_reserved(input logic [15:0] a);
      is_reserved = in_range(a, prodinfo_pkg::ADDR_RSVD_A_LO,
                             prodinfo_pkg::ADDR_RSVD_A_HI)
                    || (a == prodinfo_pkg::ADDR_RSVD_B)
                    || in_range(a, prodinfo_pkg::ADDR_RSVD_C_LO,
                                prodinfo_pkg::ADDR_RSVD_C_HI);
   endfunction

   // not used and out-of-window numbers fall to REG_NONE and are refused
   function automatic reg_sel_t decode(input logic [15:0] a);
      if (a == prodinfo_pkg::ADDR_LANGUAGE) begin
         decode = REG_LANGUAGE;
      end else if (a == prodinfo_pkg::ADDR_FW_BUILD) begin
         decode = REG_FW_BUILD;
      end else if (a == prodinfo_pkg::ADDR_SUPPORT) begin
         decode = REG_SUPPORT;
      end else if (a == prodinfo_pkg::ADDR_TIMEOUT) begin
         decode = REG_TIMEOUT;
      end else if (a == prodinfo_pkg::ADDR_CONFIGURED) begin
         decode = REG_CONFIGURED;
      end else if (a == prodinfo_pkg::ADDR_ERR_FLAGS) begin
         decode = REG_ERR_FLAGS;
      end else if (a == prodinfo_pkg::ADDR_ERR_LOC) begin
         decode = REG_ERR_LOC;
      end else if (is_reserved(a)) begin
         decode = REG_RESERVED;
      end else begin
         decode = REG_NONE;
      end
   endfunction

   function automatic prodinfo_pkg::reg_rsp_t read_word(input state_t s, input reg_sel_t sel);
      read_word = '0;
      read_word.ack = 1'b1;
      read_word.exc = prodinfo_pkg::EXC_NONE;
      case (sel)
         REG_LANGUAGE: begin
            // R1 R2 language read
            read_word.rdata = {12'h000, s.lang};
         end
         REG_FW_BUILD: begin
            read_word.rdata = FW_BUILD;
         end
         REG_SUPPORT: begin
            // R3 io card bit
            read_word.rdata[prodinfo_pkg::SUPPORT_IO2_BIT] = s.io2;
         end
         REG_TIMEOUT: begin
            read_word.rdata = s.timeout;
         end
         REG_CONFIGURED: begin
            // R5 configured bit
            read_word.rdata[prodinfo_pkg::CONFIGURED_BIT] = s.configured;
         end
         REG_ERR_FLAGS: begin
            read_word.rdata = s.err_flags;
         end
         REG_ERR_LOC: begin
            read_word.rdata = s.err_loc;
         end
         REG_RESERVED: begin
            // R8 reserved reads zero
            read_word.rdata = prodinfo_pkg::RSVD_VALUE;
         end
         default: begin
            read_word.exc = prodinfo_pkg::EXC_BAD_ADDR;
         end
      endcase
   endfunction

   // ==========================================================
   // next state
   always_comb begin
      logic [15:0] err_set;
      reg_sel_t sel;
      err_set = 16'h0000;
      sel = REG_NONE;
      next_state = state;
      next_state.rsp.ack = 1'b0;
      next_state.rsp.exc = prodinfo_pkg::EXC_NONE;
      next_state.rsp.rdata = 16'h0000;

      // R1 R2 sample language code
      // unknown codes fall back to english so the master never sees junk
      if (language_i <= prodinfo_pkg::LANG_MAX) begin
         next_state.lang = language_i;
      end else begin
         next_state.lang = prodinfo_pkg::LANG_ENGLISH;
      end
      next_state.io2 = io2_installed_i;
      next_state.configured = unit_configured_i;

      // R6 R7 sticky error bits
      // set wins over clear so a same-cycle event is never lost
      err_set = err_evt_i.set & prodinfo_pkg::ERR_VALID_MASK;
      next_state.err_flags = ((state.err_flags & ~err_evt_i.clr) | err_set)
                             & prodinfo_pkg::ERR_VALID_MASK;

      // R11 capture error address
      if (err_set != 16'h0000) begin
         next_state.err_loc = err_evt_i.addr;
      end

      // R10 raw register number
      sel = decode(req_i.addr);
      if (req_i.valid) begin
         next_state.rsp.ack = 1'b1;
         if (!req_i.write) begin
            next_state.rsp = read_word(state, sel);
         end else begin
            if (sel == REG_TIMEOUT) begin
               // R4 timeout write range
               if (req_i.wdata >= prodinfo_pkg::TIMEOUT_MIN) begin
                  next_state.timeout = req_i.wdata;
               end else begin
                  next_state.rsp.exc = prodinfo_pkg::EXC_BAD_VALUE;
               end
            end else begin
               // R9 refuse read-only write
               // nothing stored, so a stray write cannot corrupt status
               next_state.rsp.exc = prodinfo_pkg::EXC_BAD_ADDR;
            end
         end
      end
   end

   // ==========================================================
   // registers
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state.rsp.ack <= 1'b0;
         state.rsp.exc <= prodinfo_pkg::EXC_NONE;
         state.rsp.rdata <= 16'h0000;
         // R4 timeout reset value
         state.timeout <= prodinfo_pkg::TIMEOUT_RESET;
         // R6 error word reset
         state.err_flags <= prodinfo_pkg::ERR_FLAGS_RESET;
         state.err_loc <= prodinfo_pkg::ERR_LOC_RESET;
         // R2 default english
         state.lang <= prodinfo_pkg::LANG_ENGLISH;
         state.io2 <= 1'b0;
         // R5 configured default
         state.configured <= 1'b0;
      end else begin
         state <= next_state;
      end
   end

   // ==========================================================
   // outputs
   assign rsp_o = state.rsp;
   assign timeout_ms_o = state.timeout;
   assign error_flags_o = state.err_flags;

endmodule

// file: verification/prodinfo_chk.sv
/* checker for the product info window;
   assumes it is bound to the top module and sees only its ports. */
`timescale 1ns/1ps
module prodinfo_chk (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire prodinfo_pkg::reg_req_t req_i,
   input wire prodinfo_pkg::err_evt_t err_evt_i,
   input wire prodinfo_pkg::reg_rsp_t rsp_o,
   input wire logic [15:0] timeout_ms_o,
   input wire logic [15:0] error_flags_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   wire logic wr = req_i.valid && req_i.write;
   wire logic tw = wr && req_i.addr == 16'h4010;
   wire logic lo = tw && req_i.wdata < 16'h01f4;
   wire logic [15:0] vs = err_evt_i.set & 16'h3dff;
   a_ack_next: assert property (rsp_o.ack == $past(req_i.valid)) else $error("ack late");
   a_idle_quiet: assert property (!rsp_o.ack |-> !rsp_o.exc && !rsp_o.rdata) else $error("idle");
   a_ro_refused: assert property (wr && !tw |=> rsp_o.exc == 8'h02) else $error("ro write");
   a_low_kept: assert property (
      lo |=> rsp_o.exc == 8'h03 && $stable(timeout_ms_o)) else $error("low value");
   a_tmo_load: assert property (
      tw && !lo |=> timeout_ms_o == $past(req_i.wdata)) else $error("no load");
   a_err_set: assert property (
      |vs |=> (error_flags_o & $past(vs)) == $past(vs)) else $error("no set");
   a_err_rsvd: assert property (!error_flags_o[9] && !error_flags_o[15:14]) else $error("rsvd");
   a_rsvd_zero: assert property (
      req_i.valid && !req_i.write && req_i.addr == 16'h4015 |=> !rsp_o.rdata && !rsp_o.exc)
      else $error("rsvd read");
   c_load: cover property (tw);
   c_low: cover property (lo);
   c_err: cover property (|vs);
endmodule
bind product_info_status_registers prodinfo_chk u_chk (.clk_i, .rst_n_i, .req_i, .err_evt_i,
   .rsp_o, .timeout_ms_o, .error_flags_o);

// file: verification/modbus_master_model.sv
/* master model issuing one register request at a time;
   assumes the window acks each request on the next edge. */
`timescale 1ns/1ps
module modbus_master_model (
   input wire logic clk_i,
   input wire prodinfo_pkg::reg_rsp_t rsp_i,
   output prodinfo_pkg::reg_req_t req_o
);
   initial req_o = '0;
   // register number sent as the raw address field
   task automatic xfer(input logic w, input logic [15:0] a, d, output logic [24:0] r);
      @(posedge clk_i) req_o <= '{1'b1, w, a, d};
      @(posedge clk_i) req_o <= '0;
      // answer stands in the cycle after the taking edge, so take it at the next edge
      @(posedge clk_i) r = {rsp_i.ack, rsp_i.exc, rsp_i.rdata};
   endtask
endmodule

// file: verification/tb.sv
/* testbench for the product info window;
   assumes the master model drives requests and status levels come from here. */
`timescale 1ns/1ps
module tb;
   logic clk_i = 1'b0, rst_n_i = 1'b0, io2_installed_i = 1'b0, unit_configured_i = 1'b0;
   logic [3:0] language_i = 4'h0;
   prodinfo_pkg::err_evt_t err_evt_i = '0;
   prodinfo_pkg::reg_req_t req_i;
   prodinfo_pkg::reg_rsp_t rsp_o;
   logic [15:0] timeout_ms_o, error_flags_o;
   logic [15:0] rsv [4] = '{16'h4011, 16'h4015, 16'h4018, 16'h401f};
   int n_errors = 0, compares = 0;
   initial forever #4 clk_i = ~clk_i;
   // arbitrary build value, unlike the default so the read proves the parameter
   localparam logic [15:0] BUILD = 16'h0a5c;
   product_info_status_registers #(.FW_BUILD(BUILD)) u_dut (.clk_i, .rst_n_i, .req_i,
      .language_i, .io2_installed_i, .unit_configured_i, .err_evt_i, .rsp_o, .timeout_ms_o,
      .error_flags_o);
   modbus_master_model u_master (.clk_i, .rsp_i(rsp_o), .req_o(req_i));
   task automatic chk(input logic [24:0] got, exp);
      compares++;
      if (got !== exp) n_errors++;
      if (got !== exp) $display("unexpected t=%0t got %h exp %h", $time, got, exp);
   endtask
   task automatic acc(input logic w, input logic [15:0] a, d, input logic [23:0] e);
      logic [24:0] r;
      u_master.xfer(w, a, d, r);
      chk(r, {1'b1, e});
   endtask
   task automatic wrap_up();
      $display("compares %0d mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // the tests need about 134 cycles; a hang stops here
   initial begin
      repeat (3000) @(posedge clk_i);
      n_errors++;
      wrap_up();
   end
   initial begin
      repeat (3) @(posedge clk_i);
      rst_n_i <= 1'b1;
      // ==========================================================
      // reset values, reserved reads, refusals
      acc(0, 16'h4010, 0, 24'h0002ee);
      acc(0, 16'h4016, 0, 24'h0);
      acc(0, 16'h4017, 0, 24'h0);
      acc(0, 16'h4014, 0, 24'h0);
      foreach (rsv[i]) acc(0, rsv[i], 0, 24'h0);
      acc(1, 16'h4010, 16'h01f4, 24'h0);
      acc(1, 16'h4010, 16'h01f3, 24'h030000);
      acc(0, 16'h4010, 0, 24'h0001f4);
      acc(1, 16'h4010, 16'hffff, 24'h0);
      acc(0, 16'h4010, 0, 24'h00ffff);
      acc(1, 16'h400d, 16'h1234, 24'h020000);
      chk(25'(timeout_ms_o), 25'h00ffff);
      acc(0, 16'h400d, 0, {8'h00, BUILD});
      acc(0, 16'h400e, 0, 24'h020000);
      $display("test access done");
      // codes above 9 must read back as english
      for (int i = 0; i < 12; i++) begin
         @(posedge clk_i) language_i <= 4'(i);
         @(posedge clk_i);
         acc(0, 16'h400c, 0, 24'(i > 9 ? 0 : i));
      end
      @(posedge clk_i) {io2_installed_i, unit_configured_i} <= 2'b11;
      // set and clear of every bit in the same cycle: set must win
      @(posedge clk_i) err_evt_i <= '{16'hffff, 16'hffff, 16'h1234};
      @(posedge clk_i) err_evt_i <= '0;
      acc(0, 16'h400f, 0, 24'h1);
      acc(0, 16'h4014, 0, 24'h1);
      acc(0, 16'h4016, 0, 24'h3dff);
      chk(25'(error_flags_o), 25'h003dff);
      acc(0, 16'h4017, 0, 24'h1234);
      @(posedge clk_i) err_evt_i <= '{16'h0400, 16'h0001, 16'h4321};
      @(posedge clk_i) err_evt_i <= '0;
      acc(0, 16'h4016, 0, 24'h3dfe);
      acc(0, 16'h4017, 0, 24'h4321);
      $display("test status done");
      wrap_up();
   end
endmodule
